// ===== hw/sfm_top.sv
// Purpose: silence flags, five flexible pins and spindle motor output stage
// Assumes: audio words, mute, rom mode and motor inputs come from logic on clk_sys
// Notes: flex pins one and two are asynchronous and pass two flip-flops
`timescale 1ns/1ps
`include "sfm_cfg.svh"

// Contract
// - all-zero or all-ones word counts as silent
// - flag low after 250 ms continuous silence
// - mute or rom mode forces flags low
// - single-pin flag needs both channels silent
// - two-pin: left on main, right on three
// - audio off disables detection, pins stay driven
// - input one selects external or internal off-track
// - input two readable via status select or status register
// - output three: right flag, zero or one
// - high config zero selects four-line; else output four
// - output five: de-emphasis, zero or one
// - four motor modes selected by mode field
// - motor demand from fifo fill and speed
// - pdm 50 percent means no drive
// - pdm second output inverts first, 1 MHz edges
// - pwm accel on first, brake on second
// - four-line mode uses outputs four and five
// - fifo-position mode: half full gives 60 percent
module sfm_top #(
  parameter int SPEED_N = 1,
  parameter int SILENCE_CYC = `SFM_SILENCE_CYC,
  parameter int PWM_CYC = `SFM_PWM_CYC / SPEED_N,
  parameter int CDV_CYC = `SFM_CDV_CYC / SPEED_N
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [`SFM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sfm_pkg::sfm_audio_t audio_in,
  input wire logic audio_mute,
  input wire logic cdrom_mode,
  input wire logic subcode_serial,
  input wire logic deemph_flag,
  input wire logic int_off_track,
  input wire logic signed [4:0] fifo_pos,
  input wire logic signed [7:0] speed_err,
  input wire logic flex_input_one,
  input wire logic flex_input_two,
  output logic silence_flag_n,
  output logic flex_output_three,
  output logic flex_output_four,
  output logic flex_output_five,
  output logic motor_drive_a,
  output logic motor_drive_b,
  output logic off_track,
  output logic decoder_status
);

  localparam logic [7:0] PDM_CYC = 8'(`SFM_PDM_CYC / SPEED_N);

  sfm_pkg::sfm_state_t s_q;
  sfm_pkg::sfm_state_t s_d;

  always_comb
  begin
    logic [15:0] dem_raw;
    logic signed [15:0] dem;
    logic [6:0] mag;
    logic [63:0] thr_pwm;
    logic [63:0] thr_cdv;
    logic [5:0] fill;
    logic pwm_on;
    logic cdv_on;
    logic pdm_tick;
    logic l_quiet;
    logic r_quiet;
    logic kill_force;
    logic [3:0] stat_vec;
    logic want_acc;
    logic want_brk;
    dem_raw = 16'h0000;
    dem = 16'sh0000;
    mag = 7'h00;
    thr_pwm = 64'h0;
    thr_cdv = 64'h0;
    fill = 6'h00;
    pwm_on = 1'b0;
    cdv_on = 1'b0;
    pdm_tick = 1'b0;
    l_quiet = 1'b0;
    r_quiet = 1'b0;
    kill_force = 1'b0;
    stat_vec = 4'h0;
    want_acc = 1'b0;
    want_brk = 1'b0;
    s_d = s_q;

    // pin synchronisers
    s_d.flex_in_one = {s_q.flex_in_one[0], flex_input_one};
    s_d.flex_in_two = {s_q.flex_in_two[0], flex_input_two};

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `SFM_REG_FLEX_LOW: s_d.flex_low = reg_wdata[3:0];
        `SFM_REG_FLEX_HIGH: s_d.flex_high = reg_wdata[3:0];
        `SFM_REG_MOTOR_MODE: s_d.motor_mode = sfm_pkg::sfm_motor_mode_t'(reg_wdata[1:0]);
        `SFM_REG_STAT_SEL: s_d.stat_sel = reg_wdata[1:0];
        `SFM_REG_AUDIO_CFG: s_d.audio_off = reg_wdata[0];
        default: s_d.flex_low = s_q.flex_low;
      endcase
    end

    // silence detection per channel
    l_quiet = (audio_in.left == 16'h0000) || (audio_in.left == 16'hFFFF);
    r_quiet = (audio_in.right == 16'h0000) || (audio_in.right == 16'hFFFF);
    if (audio_in.valid)
    begin
      s_d.left_zero_run = l_quiet;
      s_d.right_zero_run = r_quiet;
    end
    if (s_q.audio_off || (audio_in.valid && !l_quiet))
    begin
      s_d.left_cnt = 32'h0;
      s_d.left_silent = 1'b0;
    end
    else if (s_q.left_zero_run || (audio_in.valid && l_quiet))
    begin
      if (s_q.left_cnt >= 32'(SILENCE_CYC - 1))
        s_d.left_silent = 1'b1;
      else
        s_d.left_cnt = s_q.left_cnt + 32'h1;
    end
    if (s_q.audio_off || (audio_in.valid && !r_quiet))
    begin
      s_d.right_cnt = 32'h0;
      s_d.right_silent = 1'b0;
    end
    else if (s_q.right_zero_run || (audio_in.valid && r_quiet))
    begin
      if (s_q.right_cnt >= 32'(SILENCE_CYC - 1))
        s_d.right_silent = 1'b1;
      else
        s_d.right_cnt = s_q.right_cnt + 32'h1;
    end
    if (s_q.audio_off)
    begin
      s_d.left_zero_run = 1'b0;
      s_d.right_zero_run = 1'b0;
    end

    // silence flag pins, always driven
    kill_force = audio_mute || cdrom_mode;
    if (kill_force)
      s_d.silence_flag_n = 1'b0;
    else if (s_q.flex_low[`SFM_FL_TWO_PIN])
      s_d.silence_flag_n = !s_q.left_silent;
    else
      s_d.silence_flag_n = !(s_q.left_silent && s_q.right_silent);

    if (!s_q.flex_low[`SFM_FL_OUT3_LO])
      s_d.flex_output_three = kill_force ? 1'b0 : !s_q.right_silent;
    else
      s_d.flex_output_three = s_q.flex_low[`SFM_FL_OUT3_HI];

    // off-track source and status selection
    s_d.off_track = s_q.flex_low[`SFM_FL_EXT_OFFTRACK] ? s_q.flex_in_one[1] : int_off_track;
    stat_vec = {s_q.right_silent, s_q.left_silent, s_q.flex_in_two[1], s_q.flex_in_one[1]};
    s_d.decoder_status = stat_vec[s_q.stat_sel];

    // motor demand, saturated to seven bits of magnitude
    dem_raw = 16'($signed(fifo_pos) * `SFM_FIFO_GAIN + $signed(speed_err));
    dem = $signed(dem_raw);
    if (dem > 16'sd127)
      dem = 16'sd127;
    else if (dem < -16'sd127)
      dem = -16'sd127;
    mag = dem[15] ? 7'(-dem) : dem[6:0];
    // demand direction, shared by every leg of the bridge
    want_acc = !dem[15] && (mag != 7'h00);
    want_brk = dem[15];

    // pulse density modulator on a 1 MHz enable
    if (s_q.pdm_div >= PDM_CYC - 8'h01)
    begin
      s_d.pdm_div = 8'h00;
      pdm_tick = 1'b1;
    end
    else
      s_d.pdm_div = s_q.pdm_div + 8'h01;
    if (pdm_tick)
      s_d.pdm_acc = {1'b0, s_q.pdm_acc[7:0]} + {1'b0, dem[7:0] + 8'h80};

    // pwm carriers
    s_d.pwm_cnt = (s_q.pwm_cnt >= 32'(PWM_CYC - 1)) ? 32'h0 : s_q.pwm_cnt + 32'h1;
    s_d.cdv_cnt = (s_q.cdv_cnt >= 32'(CDV_CYC - 1)) ? 32'h0 : s_q.cdv_cnt + 32'h1;
    thr_pwm = (64'(mag) * 64'(PWM_CYC)) >> 7;
    pwm_on = 64'(s_q.pwm_cnt) < thr_pwm;
    fill = 6'($signed(fifo_pos) + `SFM_FIFO_HALF_OFS);
    thr_cdv = (64'(fill) * 64'(CDV_CYC)) / `SFM_FIFO_SPAN;
    cdv_on = 64'(s_q.cdv_cnt) < thr_cdv;

    // motor output modes
    unique case (s_q.motor_mode)
      sfm_pkg::SFM_MOTOR_PDM:
      begin
        if (pdm_tick)
          s_d.motor_drive_a = s_d.pdm_acc[8];
        // b tracks a at once, so entering this mode never leaves both legs equal
        s_d.motor_drive_b = !s_d.motor_drive_a;
      end
      sfm_pkg::SFM_MOTOR_PWM2, sfm_pkg::SFM_MOTOR_PWM4:
      begin
        // a leg that was on keeps the other off for one cycle on a sign change
        s_d.motor_drive_a = pwm_on && want_acc && !s_q.motor_drive_b;
        s_d.motor_drive_b = pwm_on && want_brk && !s_q.motor_drive_a;
      end
      sfm_pkg::SFM_MOTOR_FIFO_POS:
      begin
        s_d.motor_drive_a = cdv_on;
        s_d.motor_drive_b = 1'b0;
      end
    endcase

    // outputs four and five
    if (s_q.flex_high == `SFM_FH_FOUR_LINE)
    begin
      if (s_q.motor_mode == sfm_pkg::SFM_MOTOR_PWM4)
      begin
        // break before make on the low-side legs of the bridge
        s_d.flex_output_four = want_acc && !s_q.flex_output_five;
        s_d.flex_output_five = want_brk && !s_q.flex_output_four;
      end
      else
      begin
        s_d.flex_output_four = 1'b0;
        s_d.flex_output_five = 1'b0;
      end
    end
    else
    begin
      unique case (s_q.flex_high[1:0])
        `SFM_FX_SUBCODE: s_d.flex_output_four = subcode_serial;
        `SFM_FX_ZERO: s_d.flex_output_four = 1'b0;
        `SFM_FX_ONE: s_d.flex_output_four = 1'b1;
        default: s_d.flex_output_four = 1'b0;
      endcase
      unique case (s_q.flex_high[3:2])
        `SFM_FX_DEEMPH: s_d.flex_output_five = deemph_flag;
        `SFM_FX_ZERO: s_d.flex_output_five = 1'b0;
        `SFM_FX_ONE: s_d.flex_output_five = 1'b1;
        default: s_d.flex_output_five = 1'b0;
      endcase
    end

    // read data, valid in the cycle after the read strobe
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SFM_REG_MOTOR_MODE: s_d.rdata = {6'h00, s_q.motor_mode};
        `SFM_REG_STAT_SEL: s_d.rdata = {6'h00, s_q.stat_sel};
        `SFM_REG_AUDIO_CFG: s_d.rdata = {7'h00, s_q.audio_off};
        `SFM_REG_STATUS: s_d.rdata = {4'h0, stat_vec};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.flex_low <= `SFM_FLEX_LOW_RST;
      s_q.flex_high <= `SFM_FLEX_HIGH_RST;
      s_q.motor_mode <= sfm_pkg::sfm_motor_mode_t'(`SFM_MOTOR_MODE_RST);
      s_q.stat_sel <= `SFM_STAT_SEL_RST;
      s_q.silence_flag_n <= 1'b1;
      s_q.flex_output_three <= 1'b1;
      s_q.motor_drive_b <= 1'b1;
      s_q.pdm_acc <= 9'h080;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata = s_q.rdata;
  assign silence_flag_n = s_q.silence_flag_n;
  assign flex_output_three = s_q.flex_output_three;
  assign flex_output_four = s_q.flex_output_four;
  assign flex_output_five = s_q.flex_output_five;
  assign motor_drive_a = s_q.motor_drive_a;
  assign motor_drive_b = s_q.motor_drive_b;
  assign off_track = s_q.off_track;
  assign decoder_status = s_q.decoder_status;

endmodule

// ===== hw/sfm_cfg.svh
// Purpose: constants of the silence flag, flexible pin and motor drive block
// Assumes: 200 MHz system clock, speed factor 1 by default
// Notes: times are given in their own unit, cycle counts derive from them
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH

`define SFM_CLK_HZ 200000000
// register indices on the plain register port
`define SFM_ADDR_W 5
`define SFM_REG_STAT_SEL 5'h02
`define SFM_REG_MOTOR_MODE 5'h06
`define SFM_REG_FLEX_LOW 5'h0C
`define SFM_REG_FLEX_HIGH 5'h0D
`define SFM_REG_AUDIO_CFG 5'h0E
`define SFM_REG_STATUS 5'h10
// flex_pin_config_low fields
`define SFM_FL_EXT_OFFTRACK 0
`define SFM_FL_OUT3_LO 1
`define SFM_FL_OUT3_HI 2
`define SFM_FL_TWO_PIN 3
// flex_pin_config_high values
`define SFM_FH_FOUR_LINE 4'h0
`define SFM_FX_SUBCODE 2'h1
`define SFM_FX_ZERO 2'h2
`define SFM_FX_ONE 2'h3
`define SFM_FX_DEEMPH 2'h1
// reset values
`define SFM_FLEX_LOW_RST 4'h0
`define SFM_FLEX_HIGH_RST 4'hA
`define SFM_MOTOR_MODE_RST 2'h0
`define SFM_STAT_SEL_RST 2'h0
// timing
`define SFM_SILENCE_MS 250
`define SFM_SILENCE_CYC ((`SFM_CLK_HZ / 1000) * `SFM_SILENCE_MS)
`define SFM_PDM_KHZ 1000
`define SFM_PDM_CYC (`SFM_CLK_HZ / (`SFM_PDM_KHZ * 1000))
`define SFM_PWM_HZ_X100 2205000
`define SFM_PWM_CYC ((`SFM_CLK_HZ / `SFM_PWM_HZ_X100) * 100 + ((`SFM_CLK_HZ % `SFM_PWM_HZ_X100) * 100) / `SFM_PWM_HZ_X100)
`define SFM_CDV_HZ 300
`define SFM_CDV_CYC (`SFM_CLK_HZ / `SFM_CDV_HZ)
// motor arithmetic
`define SFM_FIFO_GAIN 8
`define SFM_FIFO_SPAN 20
`define SFM_FIFO_HALF_OFS 12
`define SFM_DEMAND_MAX 127

`endif

// ===== hw/sfm_pkg.sv
// Purpose: types of the silence flag, flexible pin and motor drive block
// Assumes: constants live in sfm_cfg.svh
// Notes: whole module state is one packed struct
package sfm_pkg;

  typedef enum logic [1:0] {
    SFM_MOTOR_PDM,
    SFM_MOTOR_PWM2,
    SFM_MOTOR_PWM4,
    SFM_MOTOR_FIFO_POS
  } sfm_motor_mode_t;

  typedef struct packed {
    logic valid;
    logic [15:0] left;
    logic [15:0] right;
  } sfm_audio_t;

  typedef struct packed {
    logic [1:0] flex_in_one;
    logic [1:0] flex_in_two;
    logic [3:0] flex_low;
    logic [3:0] flex_high;
    sfm_motor_mode_t motor_mode;
    logic [1:0] stat_sel;
    logic audio_off;
    logic left_zero_run;
    logic right_zero_run;
    logic [31:0] left_cnt;
    logic [31:0] right_cnt;
    logic left_silent;
    logic right_silent;
    logic [7:0] pdm_div;
    logic [8:0] pdm_acc;
    logic [31:0] pwm_cnt;
    logic [31:0] cdv_cnt;
    logic silence_flag_n;
    logic flex_output_three;
    logic flex_output_four;
    logic flex_output_five;
    logic motor_drive_a;
    logic motor_drive_b;
    logic off_track;
    logic decoder_status;
    logic [7:0] rdata;
  } sfm_state_t;

endpackage

// ===== test/sfm_checker.sv
// Purpose: port assertions of sfm_top
// Assumes: config followed from register writes
// Notes: outputs trail a write by one cycle
`timescale 1ns/1ps
`include "sfm_cfg.svh"
module sfm_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [`SFM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic audio_mute,
  input wire logic cdrom_mode,
  input wire logic silence_flag_n,
  input wire logic flex_output_four,
  input wire logic flex_output_five,
  input wire logic motor_drive_a,
  input wire logic motor_drive_b
);
  logic [1:0] md_q, md_p;
  logic [3:0] fh_q, fh_p;
  logic ok;
  always_ff @(posedge clk_sys)
  begin
    md_p <= srst ? 2'h0 : md_q;
    fh_p <= srst ? 4'hA : fh_q;
    if (srst)
    begin
      md_q <= 2'h0;
      fh_q <= 4'hA;
    end
    else if (reg_wr && reg_addr == `SFM_REG_MOTOR_MODE)
      md_q <= reg_wdata[1:0];
    else if (reg_wr && reg_addr == `SFM_REG_FLEX_HIGH)
      fh_q <= reg_wdata[3:0];
  end
  // config unchanged for a cycle, so outputs reflect it
  assign ok = md_q == md_p && fh_q == fh_p;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  sequence s_pdm_edge;
    ok && md_q == 2'h0 && $changed(motor_drive_a);
  endsequence
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_MUTE: assert property (audio_mute || cdrom_mode |=> !silence_flag_n)
    else $error("flag not forced low");
  AST_PDM_INV: assert property (ok && md_q == 2'h0 |-> motor_drive_b == !motor_drive_a)
    else $error("pdm outputs not inverse");
  AST_PDM_STEP: assert property (s_pdm_edge |=> $stable(motor_drive_a) [*8])
    else $error("pdm edge too soon");
  AST_BRIDGE: assert property (ok && md_q == 2'h2 && fh_q == 4'h0 |-> !(flex_output_four && flex_output_five))
    else $error("both bridge paths on");
  AST_CDV_B: assert property (ok && md_q == 2'h3 |-> !motor_drive_b)
    else $error("second motor output active");
  AST_FOUR_ZERO: assert property (ok && fh_q[1:0] == 2'h2 |-> !flex_output_four)
    else $error("output four not zero");
  AST_FIVE_ONE: assert property (ok && fh_q[3:2] == 2'h3 |-> flex_output_five)
    else $error("output five not one");
  AST_LEG_EXCL: assert property (!(motor_drive_a && motor_drive_b))
    else $error("both motor legs on");
  sequence s_acc_leg_off;
    ok && md_q == 2'h2 && fh_q == 4'h0 && $fell(flex_output_four);
  endsequence
  AST_BRIDGE_GAP: assert property (s_acc_leg_off |-> !flex_output_five)
    else $error("brake leg on as accelerate leg drops");
endmodule
bind sfm_top sfm_checker sfm_checker_i (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .audio_mute, .cdrom_mode, .silence_flag_n, .flex_output_four, .flex_output_five,
  .motor_drive_a, .motor_drive_b);

// ===== test/sfm_motor_bridge.sv
// Purpose: low side of a four-input motor bridge
// Assumes: four drives the accelerate leg, five the brake leg
// Notes: shorted rises when both legs conduct together
`timescale 1ns/1ps
module sfm_motor_bridge (
  input wire logic lo_acc,
  input wire logic lo_brk,
  output logic shorted
);
  assign shorted = lo_acc && lo_brk;
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench of sfm_top
// Assumes: shortened silence, pwm and cdv counts
// Notes: outputs sampled on falling edges
`timescale 1ns/1ps
`include "sfm_cfg.svh"
module testbench;
  localparam int SIL = 100;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [`SFM_ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, audio_mute = 1'b0, cdrom_mode = 1'b0, int_off_track = 1'b0;
  logic subcode_serial = 1'b1, deemph_flag = 1'b1, flex_input_one = 1'b1, flex_input_two = 1'b0;
  logic [7:0] reg_rdata, d;
  sfm_pkg::sfm_audio_t audio_in = '0;
  logic signed [4:0] fifo_pos = '0;
  logic signed [7:0] speed_err = '0;
  logic silence_flag_n, flex_output_three, flex_output_four, flex_output_five;
  logic motor_drive_a, motor_drive_b, off_track, decoder_status, shorted;
  int failures = 0;
  int total_checks = 0;
  int ca, cb;
  sfm_top #(.SILENCE_CYC(SIL), .PWM_CYC(256), .CDV_CYC(200)) sfm_top_i (.clk_sys, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .audio_in, .audio_mute, .cdrom_mode, .subcode_serial,
    .deemph_flag, .int_off_track, .fifo_pos, .speed_err, .flex_input_one, .flex_input_two,
    .silence_flag_n, .flex_output_three, .flex_output_four, .flex_output_five, .motor_drive_a,
    .motor_drive_b, .off_track, .decoder_status);
  sfm_motor_bridge sfm_motor_bridge_i (.lo_acc(flex_output_four), .lo_brk(flex_output_five), .shorted);
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // holds one word pair on the audio input for n edges
  task aud(input logic [15:0] l, input logic [15:0] r, input int n);
    @(posedge clk_sys);
    audio_in <= '{1'b1, l, r};
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task mot(input logic [1:0] m, input int f, input int s, input int n);
    wr(`SFM_REG_MOTOR_MODE, {6'h00, m});
    fifo_pos <= f[4:0];
    speed_err <= s[7:0];
    repeat (600) @(posedge clk_sys);
    ca = 0;
    cb = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      ca += int'(motor_drive_a === 1'b1);
      cb += int'(motor_drive_b === 1'b1);
    end
  endtask
  task t_pins;
    rd(5'h1F);
    chk(d, 8'h00);
    rd(`SFM_REG_FLEX_LOW);
    chk(d, 8'h00);
    rd(`SFM_REG_STATUS);
    chk(d, 8'h01);
    chk(off_track, 1'b0);
    wr(`SFM_REG_FLEX_LOW, 8'h01);
    wr(`SFM_REG_STAT_SEL, 8'h01);
    flex_input_two <= 1'b1;
    repeat (5) @(negedge clk_sys);
    chk(off_track, 1'b1);
    chk(decoder_status, 1'b1);
    wr(`SFM_REG_FLEX_LOW, 8'h00);
    int_off_track <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(off_track, 1'b1);
    @(posedge clk_sys);
    int_off_track <= 1'b0;
    $display("pins test done");
  endtask
  task t_sil;
    aud(16'h0000, 16'hFFFF, SIL - 5);
    chk(silence_flag_n, 1'b1);
    aud(16'h0000, 16'hFFFF, 10);
    chk(silence_flag_n, 1'b0);
    rd(`SFM_REG_STATUS);
    chk(d, 8'h0F);
    aud(16'h0000, 16'h1234, 3);
    chk(silence_flag_n, 1'b1);
    wr(`SFM_REG_FLEX_LOW, 8'h08);
    aud(16'h0000, 16'h1234, 3);
    chk({silence_flag_n, flex_output_three}, 2'h1);
    aud(16'h0001, 16'h0000, SIL + 5);
    chk({silence_flag_n, flex_output_three}, 2'h2);
    aud(16'h0001, 16'h1234, 3);
    @(posedge clk_sys);
    audio_mute <= 1'b1;
    aud(16'h0001, 16'h1234, 3);
    chk({silence_flag_n, flex_output_three}, 2'h0);
    @(posedge clk_sys);
    audio_mute <= 1'b0;
    cdrom_mode <= 1'b1;
    aud(16'h0001, 16'h1234, 3);
    chk({silence_flag_n, flex_output_three}, 2'h0);
    @(posedge clk_sys);
    cdrom_mode <= 1'b0;
    wr(`SFM_REG_AUDIO_CFG, 8'h01);
    aud(16'h0000, 16'h0000, SIL + 5);
    chk({silence_flag_n, flex_output_three}, 2'h3);
    wr(`SFM_REG_AUDIO_CFG, 8'h00);
    $display("silence test done");
  endtask
  task t_flex;
    static logic [3:0] fl [4] = '{4'h2, 4'h6, 4'h2, 4'h6};
    static logic [3:0] fh [4] = '{4'hD, 4'h6, 4'hA, 4'hB};
    static logic [2:0] ex [4] = '{3'h3, 3'h5, 3'h0, 3'h6};
    for (int i = 0; i < 4; i++)
    begin
      wr(`SFM_REG_FLEX_LOW, {4'h0, fl[i]});
      wr(`SFM_REG_FLEX_HIGH, {4'h0, fh[i]});
      repeat (2) @(negedge clk_sys);
      chk({flex_output_three, flex_output_four, flex_output_five}, ex[i]);
    end
    @(posedge clk_sys);
    subcode_serial <= 1'b0;
    deemph_flag <= 1'b0;
    wr(`SFM_REG_FLEX_HIGH, 8'h05);
    repeat (2) @(negedge clk_sys);
    chk({flex_output_three, flex_output_four, flex_output_five}, 3'h4);
    wr(`SFM_REG_FLEX_LOW, 8'h00);
    $display("flex test done");
  endtask
  task t_motor;
    mot(2'h0, 0, 0, 8000);
    chk(16'(ca > 3600 && ca < 4400), 16'h0001);
    chk(16'(ca + cb), 16'h1F40);
    mot(2'h0, 4, 0, 8000);
    chk(16'(ca > 4600 && ca < 5400), 16'h0001);
    mot(2'h1, 2, 16, 2560);
    chk({16'(ca), 16'(cb)}, {16'h0280, 16'h0000});
    mot(2'h1, -4, 0, 2560);
    chk({16'(ca), 16'(cb)}, {16'h0000, 16'h0280});
    wr(`SFM_REG_FLEX_HIGH, 8'h00);
    mot(2'h2, 4, 0, 16);
    chk({flex_output_four, flex_output_five, shorted}, 3'h4);
    mot(2'h2, -4, 0, 16);
    chk({flex_output_four, flex_output_five, shorted}, 3'h2);
    mot(2'h3, 0, 0, 2000);
    chk({16'(ca), 16'(cb)}, {16'h04B0, 16'h0000});
    $display("motor test done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    t_pins();
    t_sil();
    t_flex();
    t_motor();
    print_verdict();
  end
  initial
  begin
    #300000;
    failures++;
    print_verdict();
  end
endmodule
